/* port_cfg.v */
// Direction, analog-select and data registers for five general-purpose ports
`timescale 1ns/100ps
`include "port_cfg_defines.vh"

module port_cfg (
    input wire clk_in,
    input wire rstn_in,
    input wire [3:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    output reg [7:0] rdata_out,
    input wire [7:0] pin_a_in,
    input wire [7:0] pin_b_in,
    input wire [7:0] pin_c_in,
    input wire [7:0] pin_d_in,
    input wire [2:0] pin_e_in,
    output reg [7:0] pin_a_out,
    output reg [7:0] pin_b_out,
    output reg [7:0] pin_c_out,
    output reg [7:0] pin_d_out,
    output reg [2:0] pin_e_out,
    output reg [7:0] pin_a_oen_out,
    output reg [7:0] pin_b_oen_out,
    output reg [7:0] pin_c_oen_out,
    output reg [7:0] pin_d_oen_out,
    output reg [2:0] pin_e_oen_out,
    output reg [2:0] input_buffer_disable_out,
    output reg pin3_weak_pullup_enable_out
);

    // ----------------------------------------------------------------
    // Registers
    // ----------------------------------------------------------------
    reg [7:0] dir_a_q, dir_b_q, dir_c_q, dir_d_q;
    reg [7:0] dir_e_q;
    reg [7:0] ansel_e_q;
    reg [7:0] out_a_q, out_b_q, out_c_q, out_d_q, out_e_q;
    reg [7:0] rdata_d;
    wire [7:0] in_e;
    wire [7:0] dir_e_d;
    wire [7:0] ansel_d;
    wire [7:0] out_e_d;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Keeps only the implemented bits of a byte; shared by every partly
    // implemented register and by the fifth port's input view
    function [7:0] keep_bits(input [7:0] value, input [7:0] mask);
        keep_bits = value & mask;
    endfunction

    // Analog pins read zero; digital buffer is off so the pin level is void
    assign in_e = keep_bits({5'h00, pin_e_in}, ~ansel_e_q);

    // Unimplemented bits are masked on write so they can never read back set
    assign dir_e_d = keep_bits(wdata_in, `E_DIR_MASK);
    assign ansel_d = keep_bits(wdata_in, `ANSEL_MASK);
    assign out_e_d = keep_bits(wdata_in, `OUT_E_MASK);

    // ----------------------------------------------------------------
    // Register writes
    // ----------------------------------------------------------------
    // Full-width directions reset to inputs, so no pin drives the board
    // before software has picked a direction
    always @(posedge clk_in) begin
        if (!rstn_in) begin
            dir_a_q <= `DIR_RST;
            dir_b_q <= `DIR_RST;
            dir_c_q <= `DIR_RST;
            dir_d_q <= `DIR_RST;
        end else if (wr_in) begin
            case (addr_in)
                `OFS_DIR_A: dir_a_q <= wdata_in;
                `OFS_DIR_B: dir_b_q <= wdata_in;
                `OFS_DIR_C: dir_c_q <= wdata_in;
                `OFS_DIR_D: dir_d_q <= wdata_in;
                default: ;
            endcase
        end
    end

    // Fifth port starts as inputs with pull-up on and buffers off;
    // the gap bits are masked before they reach the flops
    always @(posedge clk_in) begin
        if (!rstn_in) begin
            dir_e_q <= `DIR_E_RST;
            ansel_e_q <= `ANSEL_RST;
        end else if (wr_in) begin
            case (addr_in)
                `OFS_DIR_E: dir_e_q <= dir_e_d;
                `OFS_ANSEL_E: ansel_e_q <= ansel_d;
                default: ;
            endcase
        end
    end

    // Output data registers; a value reaches its pin only while the
    // pin drives, so it may be preloaded before the direction flips
    always @(posedge clk_in) begin
        if (!rstn_in) begin
            out_a_q <= `OUT_RST;
            out_b_q <= `OUT_RST;
            out_c_q <= `OUT_RST;
            out_d_q <= `OUT_RST;
            out_e_q <= `OUT_RST;
        end else if (wr_in) begin
            case (addr_in)
                `OFS_OUT_A: out_a_q <= wdata_in;
                `OFS_OUT_B: out_b_q <= wdata_in;
                `OFS_OUT_C: out_c_q <= wdata_in;
                `OFS_OUT_D: out_d_q <= wdata_in;
                `OFS_OUT_E: out_e_q <= out_e_d;
                default: ;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Read mux
    // ----------------------------------------------------------------
    // Pin inputs are sampled straight; they are taken as synchronous
    always @* begin
        case (addr_in)
            `OFS_DIR_A: rdata_d = dir_a_q;
            `OFS_DIR_B: rdata_d = dir_b_q;
            `OFS_DIR_C: rdata_d = dir_c_q;
            `OFS_DIR_D: rdata_d = dir_d_q;
            `OFS_DIR_E: rdata_d = dir_e_q;
            `OFS_ANSEL_E: rdata_d = ansel_e_q;
            `OFS_IN_A: rdata_d = pin_a_in;
            `OFS_IN_B: rdata_d = pin_b_in;
            `OFS_IN_C: rdata_d = pin_c_in;
            `OFS_IN_D: rdata_d = pin_d_in;
            `OFS_IN_E: rdata_d = in_e;
            `OFS_OUT_A: rdata_d = out_a_q;
            `OFS_OUT_B: rdata_d = out_b_q;
            `OFS_OUT_C: rdata_d = out_c_q;
            `OFS_OUT_D: rdata_d = out_d_q;
            `OFS_OUT_E: rdata_d = out_e_q;
            default: rdata_d = 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the strobe, zero otherwise
    always @(posedge clk_in) begin
        if (!rstn_in) begin
            rdata_out <= 8'h00;
        end else if (rd_in) begin
            rdata_out <= rdata_d;
        end else begin
            rdata_out <= 8'h00;
        end
    end

    // ----------------------------------------------------------------
    // Pin drive, registered so outputs come from flip-flops
    // ----------------------------------------------------------------
    // Enable is low while driving: a direction bit of one tri-states the pin.
    // One cycle of lag after a register write is the price of flopped pins.
    // Port A enable and data
    always @(posedge clk_in) begin
        if (!rstn_in) begin
            pin_a_oen_out <= `DIR_RST;
            pin_a_out <= `OUT_RST;
        end else begin
            pin_a_oen_out <= dir_a_q;
            pin_a_out <= out_a_q;
        end
    end

    // Port B enable and data
    always @(posedge clk_in) begin
        if (!rstn_in) begin
            pin_b_oen_out <= `DIR_RST;
            pin_b_out <= `OUT_RST;
        end else begin
            pin_b_oen_out <= dir_b_q;
            pin_b_out <= out_b_q;
        end
    end

    // Port C enable and data
    always @(posedge clk_in) begin
        if (!rstn_in) begin
            pin_c_oen_out <= `DIR_RST;
            pin_c_out <= `OUT_RST;
        end else begin
            pin_c_oen_out <= dir_c_q;
            pin_c_out <= out_c_q;
        end
    end

    // Port D enable and data
    always @(posedge clk_in) begin
        if (!rstn_in) begin
            pin_d_oen_out <= `DIR_RST;
            pin_d_out <= `OUT_RST;
        end else begin
            pin_d_oen_out <= dir_d_q;
            pin_d_out <= out_d_q;
        end
    end

    // Fifth port: only the three low bits reach real pins
    always @(posedge clk_in) begin
        if (!rstn_in) begin
            pin_e_oen_out <= `PIN_E_OEN_RST;
            pin_e_out <= `PIN_E_OUT_RST;
        end else begin
            pin_e_oen_out <= dir_e_q[2:0];
            pin_e_out <= out_e_q[2:0];
        end
    end

    // Analog select and pull-up sit apart from drive; the pull-up is
    // left to software even while the pin drives
    always @(posedge clk_in) begin
        if (!rstn_in) begin
            input_buffer_disable_out <= `BUF_OFF_RST;
            pin3_weak_pullup_enable_out <= `PULLUP_RST;
        end else begin
            input_buffer_disable_out <= ansel_e_q[2:0];
            pin3_weak_pullup_enable_out <= dir_e_q[`PULLUP_BIT];
        end
    end

endmodule

/* port_cfg_defines.vh */
// Offsets, fields and reset values of the port configuration block
`ifndef PORT_CFG_DEFINES_VH
`define PORT_CFG_DEFINES_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ADDR_W 4
`define OFS_DIR_A 4'h0
`define OFS_DIR_B 4'h1
`define OFS_DIR_C 4'h2
`define OFS_DIR_D 4'h3
`define OFS_DIR_E 4'h4
`define OFS_ANSEL_E 4'h5
`define OFS_IN_A 4'h6
`define OFS_IN_B 4'h7
`define OFS_IN_C 4'h8
`define OFS_IN_D 4'h9
`define OFS_IN_E 4'hA
`define OFS_OUT_A 4'hB
`define OFS_OUT_B 4'hC
`define OFS_OUT_C 4'hD
`define OFS_OUT_D 4'hE
`define OFS_OUT_E 4'hF

// ----------------------------------------------------------------
// Fields and reset values
// ----------------------------------------------------------------
`define PULLUP_BIT 7
`define E_DIR_MASK 8'h87
`define ANSEL_MASK 8'h07
`define DIR_RST 8'hFF
`define DIR_E_RST 8'h87
`define ANSEL_RST 8'h07
`define OUT_RST 8'h00
`define OUT_E_MASK 8'h07
`define PIN_E_OEN_RST 3'h7
`define PIN_E_OUT_RST 3'h0
`define BUF_OFF_RST 3'h7
`define PULLUP_RST 1'b1

`endif

/* port_cfg_assertions.sv */
// Concurrent checks on the port configuration register block
`timescale 1ns/100ps
module port_cfg_checker (
    input wire clk_in,
    input wire rstn_in,
    input wire [3:0] addr_in,
    input wire [7:0] wdata_in,
    input wire wr_in,
    input wire rd_in,
    input wire [7:0] rdata_out,
    input wire [2:0] pin_e_in,
    input wire [7:0] pin_a_oen_out,
    input wire [2:0] pin_e_oen_out,
    input wire [2:0] input_buffer_disable_out,
    input wire pin3_weak_pullup_enable_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    // Slices kept as nets so the past values stay plain signals
    wire [2:0] wd_lo = wdata_in[2:0];
    wire wd_top = wdata_in[7];
    sequence s_wr_e; wr_in && addr_in == 4'h4; endsequence
    sequence s_wr_an; wr_in && addr_in == 4'h5; endsequence
    dir_a_drive_a:
    assert property (wr_in && addr_in == 4'h0 |-> ##2
        pin_a_oen_out == $past(wdata_in, 2)) else $error("port a enable");
    dir_e_drive_a:
    assert property (s_wr_e |-> ##2 pin_e_oen_out == $past(wd_lo, 2))
        else $error("fifth port enable");
    pullup_follow_a:
    assert property (s_wr_e |-> ##2
        pin3_weak_pullup_enable_out == $past(wd_top, 2)) else $error("pullup");
    dir_e_gap_a:
    assert property (rd_in && addr_in == 4'h4 |=> rdata_out[6:3] == 4'h0)
        else $error("fifth direction gap bits");
    buf_off_follow_a:
    assert property (s_wr_an |-> ##2
        input_buffer_disable_out == $past(wd_lo, 2)) else $error("buffer");
    ansel_upper_a:
    assert property (rd_in && addr_in == 4'h5 |=> rdata_out[7:3] == 5'h00)
        else $error("analog select upper bits");
    buf_off_read_a:
    // The buffer-disable output one cycle after the read matches the
    // register that the read used, even right after a select write
    assert property (rd_in && addr_in == 4'hA |=> rdata_out[7:3] == 5'h00 &&
        rdata_out[2:0] == ($past(pin_e_in) & ~input_buffer_disable_out))
        else $error("disabled input read");
    read_idle_a:
    assert property (!rd_in |=> rdata_out == 8'h00) else $error("idle read");
endmodule

/* port_cfg_tb.sv */
// Self-checking bench for the port configuration register block
`timescale 1ns/100ps
`include "port_cfg_defines.vh"
module port_cfg_tb;
    logic clk_in = 0, rstn_in = 0, wr_in = 0, rd_in = 0, pull_up;
    logic [3:0] addr_in = 4'h0;
    logic [7:0] wdata_in = 8'h00, rdata_out, pin_out [4], oen [4];
    logic [7:0] pin_in [4] = '{default: 8'h00};
    logic [2:0] pin_e_in = 3'h0, pin_e_out, pin_e_oen_out, buf_off;
    int errors = 0, samples_checked = 0, cycles = 0;
    initial forever #2.5 clk_in = ~clk_in;
    port_cfg dut (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
        .rdata_out(rdata_out), .pin_a_in(pin_in[0]), .pin_b_in(pin_in[1]),
        .pin_c_in(pin_in[2]), .pin_d_in(pin_in[3]), .pin_e_in(pin_e_in),
        .pin_a_out(pin_out[0]), .pin_b_out(pin_out[1]),
        .pin_c_out(pin_out[2]), .pin_d_out(pin_out[3]),
        .pin_e_out(pin_e_out), .pin_a_oen_out(oen[0]),
        .pin_b_oen_out(oen[1]), .pin_c_oen_out(oen[2]),
        .pin_d_oen_out(oen[3]), .pin_e_oen_out(pin_e_oen_out),
        .input_buffer_disable_out(buf_off),
        .pin3_weak_pullup_enable_out(pull_up));
    task automatic chk(input string n, input logic [7:0] e, s);
        samples_checked++;
        if (s !== e) begin
            errors++;
            $display("FAIL %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        @(posedge clk_in);
        wr_in <= 1'b0;
    endtask
    // Read data stands one cycle only, so sample just after the taking edge
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        @(posedge clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 chk("read data", e, rdata_out);
    endtask
    // Port A pins and the fifth port's direction register must leave reset as undriven inputs
    task automatic t_reset;
        rd(`OFS_DIR_E, 8'h87);
        rd(`OFS_ANSEL_E, 8'h07);
        chk("reset enable", 8'hFF, oen[0]);
        chk("reset buffer off", 8'h07, {5'h00, buf_off});
        chk("reset pullup", 8'h01, {7'h00, pull_up});
    endtask
    task automatic t_full;
        for (int i = 0; i < 4; i++) begin
            wr(i[3:0], 8'h5A ^ i[7:0]);
            pin_in[i] <= 8'hA0 | i[7:0];
            wr(i[3:0] + 4'hB, 8'hC3);
        end
        repeat (2) @(posedge clk_in);
        #1;
        for (int i = 0; i < 4; i++) begin
            chk("enable", 8'h5A ^ i[7:0], oen[i]);
            chk("data out", 8'hC3, pin_out[i]);
            rd(i[3:0] + 4'h6, 8'hA0 | i[7:0]);
            rd(i[3:0], 8'h5A ^ i[7:0]);
            rd(i[3:0] + 4'hB, 8'hC3);
        end
    endtask
    // Gap bits written as ones must vanish on readback
    task automatic t_fifth;
        wr(`OFS_DIR_E, 8'h7E);
        wr(`OFS_OUT_E, 8'hFD);
        repeat (2) @(posedge clk_in);
        #1;
        chk("fifth enable", 8'h06, {5'h00, pin_e_oen_out});
        chk("pullup off", 8'h00, {7'h00, pull_up});
        chk("fifth data out", 8'h05, {5'h00, pin_e_out});
        rd(`OFS_DIR_E, 8'h06);
        rd(`OFS_OUT_E, 8'h05);
        wr(`OFS_DIR_E, 8'h81);
        repeat (2) @(posedge clk_in);
        #1;
        chk("pullup on", 8'h01, {7'h00, pull_up});
    endtask
    task automatic t_analog;
        wr(`OFS_ANSEL_E, 8'hFA);
        pin_e_in <= 3'h7;
        repeat (2) @(posedge clk_in);
        #1;
        chk("buffer off", 8'h02, {5'h00, buf_off});
        rd(`OFS_ANSEL_E, 8'h02);
        rd(`OFS_IN_E, 8'h05);
    endtask
    task automatic final_report;
        $display("errors %0d samples_checked %0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Hang guard well above the fewer than a hundred cycles the run needs
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 2000) begin
            errors++;
            $display("FAIL cycles expected below %0d seen %0d", 2000, cycles);
            final_report;
        end
    end
    initial begin
        repeat (6) @(posedge clk_in);
        rstn_in <= 1'b1;
        t_reset;
        t_full;
        t_fifth;
        t_analog;
        final_report;
    end
endmodule
bind port_cfg port_cfg_checker chk_u (.clk_in(clk_in), .rstn_in(rstn_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .pin_e_in(pin_e_in),
    .pin_a_oen_out(pin_a_oen_out), .pin_e_oen_out(pin_e_oen_out),
    .input_buffer_disable_out(input_buffer_disable_out),
    .pin3_weak_pullup_enable_out(pin3_weak_pullup_enable_out));
